// ==== usf_params.svh ====
// Constants of the serial status-flag block: offsets, bit positions, resets.
// Assumes byte addresses on a 32-bit classic Wishbone slave port.
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH

`define USF_ADR_W      8
`define USF_WORD_W     9
`define USF_IRQ_W      6

`define USF_OFS_STATUS 8'h00
`define USF_OFS_DATA   8'h04
`define USF_OFS_CTRL1  8'h08
`define USF_OFS_CTRL2  8'h0c
`define USF_OFS_ISTAT  8'h10
`define USF_OFS_IMASK  8'h14

`define USF_STATUS_RST 8'hc0
`define USF_CTRL_RST   8'h00
`define USF_IMASK_RST  6'h3f

// Status flag positions.
`define USF_B_TXE 7
`define USF_B_TXD 6
`define USF_B_RXF 5
`define USF_B_IDL 4
`define USF_B_OVR 3
`define USF_B_NSE 2
`define USF_B_FRM 1
`define USF_B_PAR 0

// Enable positions in the two control registers.
`define USF_C2_TXE_EN 7
`define USF_C2_TXD_EN 6
`define USF_C2_RX_EN  5
`define USF_C2_QL_EN  4
`define USF_C1_PAR_EN 0

// Sticky interrupt event positions.
`define USF_I_TXE 0
`define USF_I_TXD 1
`define USF_I_RXF 2
`define USF_I_OVR 3
`define USF_I_IDL 4
`define USF_I_PAR 5

`endif

// ==== usf_pkg.sv ====
// Types shared by the serial status-flag block.
// Assumes usf_params.svh is on the include path.
`include "usf_params.svh"

package usf_pkg;

  // Kind of frame the transmit shifter has just finished.
  typedef enum logic [1:0] {
    USF_FRAME_DATA,
    USF_FRAME_PREAMBLE,
    USF_FRAME_BREAK
  } usf_frame_e;

  // All state of the top module besides the flag, interrupt-event and word stores.
  typedef struct packed {
    logic                  ackR;
    logic [31:0]           datR;
    logic [7:0]            ctrl1;
    logic [7:0]            ctrl2;
    logic [`USF_IRQ_W-1:0] irqMask;
    logic                  armTx;
    logic                  armRx;
    logic                  armPar;
    logic                  idleArm;
    logic [`USF_WORD_W-1:0] txData;
    logic                  irqR;
  } usf_state_s;

endpackage : usf_pkg

// ==== usf_sticky_bits.sv ====
// Vector of sticky bits: a set pulse wins over a clear in the same cycle.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module usf_sticky_bits #(
  parameter int              W   = 8,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] setBits,
  input  wire logic [W-1:0] clrBits,
  output var  logic [W-1:0] q
);

  logic [W-1:0] q_nxt;

  // Set beats clear so that no event is lost in a clearing cycle.
  always_comb begin
    q_nxt = (q & ~clrBits) | setBits;
  end

  // Register the bits.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q <= RST;
    end else begin
      q <= q_nxt;
    end
  end

endmodule : usf_sticky_bits

`default_nettype wire

// ==== usf_word_store.sv ====
// One-word store for the received word; read data comes from the register.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module usf_word_store #(
  parameter int W = 9
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         wrEn,
  input  wire logic [W-1:0] wrData,
  output var  logic [W-1:0] rdData
);

  logic [W-1:0] word_nxt;

  // A word is only replaced on an explicit write, never on overrun.
  always_comb begin
    word_nxt = wrEn ? wrData : rdData;
  end

  // Register the word.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdData <= '0;
    end else begin
      rdData <= word_nxt;
    end
  end

endmodule : usf_word_store

`default_nettype wire

// ==== usf_status_flags.sv ====
// Status flags of the asynchronous serial port with a Wishbone slave port.
// Assumes the shifters, baud logic and sampler sit outside and report
// their events as one-cycle pulses synchronous to ref_clk.
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "usf_params.svh"

module usf_status_flags (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  // Classic Wishbone slave.
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`USF_ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Transmit shifter side.
  input  wire logic                    txLoad,
  input  wire logic                    txFrameDone,
  input  wire usf_pkg::usf_frame_e     txFrameKind,
  output logic [`USF_WORD_W-1:0]       txHoldData,
  output logic                         txHoldFull,
  // Receive shifter side.
  input  wire logic                    rxWordDone,
  input  wire logic [`USF_WORD_W-1:0]  rxWord,
  input  wire logic                    rxNoise,
  input  wire logic                    rxFrameErr,
  input  wire logic                    rxParityErr,
  input  wire logic                    idleDetect,
  // Shared interrupt.
  output logic                         irq
);

  usf_pkg::usf_state_s s;
  usf_pkg::usf_state_s s_nxt;

  logic [7:0]              flags;
  logic [7:0]              flagSet;
  logic [7:0]              flagClr;
  logic [`USF_IRQ_W-1:0]   iStat;
  logic [`USF_IRQ_W-1:0]   iSet;
  logic [`USF_IRQ_W-1:0]   iClr;
  logic [`USF_WORD_W-1:0]  rxHeld;
  logic                    rxStore;
  logic                    req;
  logic                    isStatus;
  logic                    isData;
  logic                    wrOk;

  // Status flags, reset to transmit-empty and transmit-done.
  usf_sticky_bits #(
    .W   (8),
    .RST (`USF_STATUS_RST)
  ) u_flags (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .setBits (flagSet),
    .clrBits (flagClr),
    .q       (flags)
  );

  // Sticky interrupt events, cleared by writing ones.
  usf_sticky_bits #(
    .W   (`USF_IRQ_W),
    .RST ('0)
  ) u_istat (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .setBits (iSet),
    .clrBits (iClr),
    .q       (iStat)
  );

  // Received word as seen through the data register.
  usf_word_store #(
    .W (`USF_WORD_W)
  ) u_rxword (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .wrEn    (rxStore),
    .wrData  (rxWord),
    .rdData  (rxHeld)
  );

  // Bus decode, flag sequencing and interrupt event generation.
  always_comb begin
    s_nxt    = s;
    flagSet  = '0;
    flagClr  = '0;
    iSet     = '0;
    iClr     = '0;
    rxStore  = 1'b0;
    // A request is served once; ack follows in the next cycle.
    req      = wb_cyc_i & wb_stb_i & ~s.ackR;
    isStatus = wb_adr_i == `USF_OFS_STATUS;
    isData   = wb_adr_i == `USF_OFS_DATA;
    wrOk     = req & wb_we_i & wb_sel_i[0];
    s_nxt.ackR = req;

    // Transmit side events.
    if (txLoad) begin
      flagSet[`USF_B_TXE] = 1'b1;
    end
    if (txFrameDone && txFrameKind == usf_pkg::USF_FRAME_DATA) begin
      flagSet[`USF_B_TXD] = 1'b1;
    end

    // Receive side: a word either lands in the store or overruns.
    if (rxWordDone) begin
      if (flags[`USF_B_RXF]) begin
        flagSet[`USF_B_OVR] = 1'b1;
      end else begin
        rxStore = 1'b1;
        flagSet[`USF_B_RXF] = 1'b1;
        flagSet[`USF_B_NSE] = rxNoise;
        flagSet[`USF_B_FRM] = rxFrameErr;
        flagSet[`USF_B_PAR] = rxParityErr;
        s_nxt.idleArm = 1'b1;
      end
    end

    // Idle is allowed once per reception.
    if (idleDetect && s.idleArm) begin
      flagSet[`USF_B_IDL] = 1'b1;
      s_nxt.idleArm = 1'b0;
    end

    // Any status access arms the clearing sequences; a read arms parity.
    if (req && isStatus) begin
      s_nxt.armTx = 1'b1;
      s_nxt.armRx = 1'b1;
      if (!wb_we_i) begin
        s_nxt.armPar = 1'b1;
      end
    end

    // A data access finishes whichever sequence it matches.
    if (req && isData) begin
      if (wb_we_i && s.armTx) begin
        flagClr[`USF_B_TXE] = 1'b1;
        flagClr[`USF_B_TXD] = 1'b1;
      end
      if (!wb_we_i && s.armRx) begin
        flagClr[`USF_B_RXF] = 1'b1;
        flagClr[`USF_B_IDL] = 1'b1;
        flagClr[`USF_B_OVR] = 1'b1;
        flagClr[`USF_B_NSE] = 1'b1;
        flagClr[`USF_B_FRM] = 1'b1;
      end
      if (s.armPar) begin
        flagClr[`USF_B_PAR] = 1'b1;
      end
      s_nxt.armTx  = 1'b0;
      s_nxt.armRx  = 1'b0;
      s_nxt.armPar = 1'b0;
    end

    // Register writes; the status register ignores writes.
    if (wrOk) begin
      unique case (wb_adr_i)
        `USF_OFS_DATA:  s_nxt.txData = wb_dat_i[`USF_WORD_W-1:0];
        `USF_OFS_CTRL1: s_nxt.ctrl1 = wb_dat_i[7:0];
        `USF_OFS_CTRL2: s_nxt.ctrl2 = wb_dat_i[7:0];
        `USF_OFS_ISTAT: iClr = wb_dat_i[`USF_IRQ_W-1:0];
        `USF_OFS_IMASK: s_nxt.irqMask = wb_dat_i[`USF_IRQ_W-1:0];
        default: ;
      endcase
    end

    // Read data is captured with the ack; unmapped words read zero.
    s_nxt.datR = '0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `USF_OFS_STATUS: s_nxt.datR[7:0] = flags;
        `USF_OFS_DATA:
          s_nxt.datR[`USF_WORD_W-1:0] = rxHeld;
        `USF_OFS_CTRL1: s_nxt.datR[7:0] = s.ctrl1;
        `USF_OFS_CTRL2: s_nxt.datR[7:0] = s.ctrl2;
        `USF_OFS_ISTAT:
          s_nxt.datR[`USF_IRQ_W-1:0] = iStat;
        `USF_OFS_IMASK:
          s_nxt.datR[`USF_IRQ_W-1:0] = s.irqMask;
        default: s_nxt.datR = '0;
      endcase
    end

    // Enabled flag events are latched as interrupt events.
    iSet[`USF_I_TXE] = flagSet[`USF_B_TXE]
                     & s.ctrl2[`USF_C2_TXE_EN];
    iSet[`USF_I_TXD] = flagSet[`USF_B_TXD]
                     & s.ctrl2[`USF_C2_TXD_EN];
    iSet[`USF_I_RXF] = flagSet[`USF_B_RXF]
                     & s.ctrl2[`USF_C2_RX_EN];
    iSet[`USF_I_OVR] = flagSet[`USF_B_OVR]
                     & s.ctrl2[`USF_C2_RX_EN];
    iSet[`USF_I_IDL] = flagSet[`USF_B_IDL]
                     & s.ctrl2[`USF_C2_QL_EN];
    iSet[`USF_I_PAR] = flagSet[`USF_B_PAR]
                     & s.ctrl1[`USF_C1_PAR_EN];

    // One shared level output; it lags the status bits by a cycle.
    s_nxt.irqR = |(iStat & s.irqMask);
  end

  // Register the whole state.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s.ackR    <= 1'b0;
      s.datR    <= '0;
      s.ctrl1   <= `USF_CTRL_RST;
      s.ctrl2   <= `USF_CTRL_RST;
      s.irqMask <= `USF_IMASK_RST;
      s.armTx   <= 1'b0;
      s.armRx   <= 1'b0;
      s.armPar  <= 1'b0;
      s.idleArm <= 1'b0;
      s.txData  <= '0;
      s.irqR    <= 1'b0;
    end else begin
      s <= s_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign wb_ack_o   = s.ackR;
  assign wb_dat_o   = s.datR;
  assign txHoldData = s.txData;
  assign txHoldFull = ~flags[`USF_B_TXE];
  assign irq        = s.irqR;

endmodule : usf_status_flags

`default_nettype wire

// ==== usf_status_flags_chk.sv ====
// Concurrent checks on the ports of the serial status-flag block.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
`include "usf_params.svh"
module usf_status_flags_chk (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        txLoad,
  input wire logic        txFrameDone,
  input wire logic        rxWordDone,
  input wire logic        idleDetect,
  input wire logic [8:0]  txHoldData,
  input wire logic        txHoldFull,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic take;
  // A request is taken only while no answer is standing.
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  sequence dataWr;
    take && wb_we_i && wb_adr_i == `USF_OFS_DATA;
  endsequence
  sequence statWr;
    take && wb_we_i && wb_adr_i == `USF_OFS_STATUS && !txLoad;
  endsequence
  ack_latency_a: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  txe_set_a: assert property (txLoad |=> !txHoldFull)
    else $error("load did not empty holding word");
  txe_cause_a: assert property ($fell(txHoldFull) |-> $past(txLoad))
    else $error("holding empty without load");
  tx_clear_a: assert property ($rose(txHoldFull) |->
    $past(take && wb_we_i && wb_adr_i == `USF_OFS_DATA))
    else $error("holding full without data write");
  hold_data_a: assert property (dataWr ##0 wb_sel_i[0] |=> txHoldData == $past(wb_dat_i[8:0]))
    else $error("holding word not stored");
  stat_write_a: assert property (statWr |=> $stable(txHoldFull))
    else $error("status write moved a flag");
  irq_cause_a: assert property ($rose(irq) |->
    $past(txLoad || txFrameDone || rxWordDone || idleDetect ||
          (take && wb_we_i), 2))
    else $error("interrupt without event");
endmodule : usf_status_flags_chk
bind usf_status_flags usf_status_flags_chk chk (
  .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .txLoad(txLoad), .txFrameDone(txFrameDone),
  .rxWordDone(rxWordDone), .idleDetect(idleDetect),
  .txHoldData(txHoldData), .txHoldFull(txHoldFull), .irq(irq));
`default_nettype wire

// ==== usf_peer_model.sv ====
// Model of the shifters and line events that feed the flag block.
// Assumes its tasks are called just after a rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module usf_peer_model (
  input  wire logic          ref_clk,
  output var  logic          txLoad,
  output var  logic          txFrameDone,
  output var  usf_pkg::usf_frame_e txFrameKind,
  output var  logic          rxWordDone,
  output var  logic [8:0]    rxWord,
  output var  logic          rxNoise,
  output var  logic          rxFrameErr,
  output var  logic          rxParityErr,
  output var  logic          idleDetect
);
  // Quiet at time zero; the line carries no event yet.
  initial begin
    {txLoad, txFrameDone, rxWordDone, idleDetect} = 4'h0;
    {rxNoise, rxFrameErr, rxParityErr} = 3'h0;
    txFrameKind = usf_pkg::USF_FRAME_DATA;
    rxWord = 9'h000;
  end
  // Word is inverted after the pulse so a stale value cannot pass.
  task automatic rxSend(input logic [8:0] w, input logic nz, fe, pe);
    @(posedge ref_clk);
    rxWordDone <= 1'b1;
    rxWord <= w;
    {rxNoise, rxFrameErr, rxParityErr} <= {nz, fe, pe};
    @(posedge ref_clk);
    rxWordDone <= 1'b0;
    rxWord <= ~w;
    {rxNoise, rxFrameErr, rxParityErr} <= 3'h0;
  endtask : rxSend
  task automatic txEv(input logic ld, dn, input usf_pkg::usf_frame_e k);
    @(posedge ref_clk);
    {txLoad, txFrameDone, idleDetect} <= {ld, dn, !(ld || dn)};
    txFrameKind <= k;
    @(posedge ref_clk);
    {txLoad, txFrameDone, idleDetect} <= 3'h0;
  endtask : txEv
endmodule : usf_peer_model
`default_nettype wire

// ==== usf_status_flags_tb_top.sv ====
// Self-checking bench of the flag block over classic Wishbone.
// Assumes the design, its checker and the peer model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "usf_params.svh"
module usf_status_flags_tb_top;
  logic        clk, rstN, cyc, stb, we, ack, full, irq;
  logic [7:0]  adr;
  logic [31:0] dati, dato, q;
  logic [8:0]  hold;
  int          n_fail, cmp_count;
  usf_peer_model peer (.ref_clk(clk), .txLoad(), .txFrameDone(),
    .txFrameKind(), .rxWordDone(), .rxWord(), .rxNoise(),
    .rxFrameErr(), .rxParityErr(), .idleDetect());
  usf_status_flags dut (.ref_clk(clk), .resetn(rstN), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
    .txLoad(peer.txLoad), .txFrameDone(peer.txFrameDone),
    .txFrameKind(peer.txFrameKind), .txHoldData(hold),
    .txHoldFull(full), .rxWordDone(peer.rxWordDone),
    .rxWord(peer.rxWord), .rxNoise(peer.rxNoise),
    .rxFrameErr(peer.rxFrameErr), .rxParityErr(peer.rxParityErr),
    .idleDetect(peer.idleDetect), .irq(irq));
  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : check
  // One classic cycle; ack and read data are taken at the same rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dati} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end else begin
      q = dato;
      {cyc, stb} <= 2'b00;
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check("read", q, e);
  endtask : rd
  // The watched signal is passed by reference so its settled value is seen.
  task automatic late(input string nm, ref logic s, input logic [31:0] e);
    repeat (3) @(negedge clk);
    check(nm, s, e);
  endtask : late
  // Reset values, unmapped place and read-only status.
  task automatic s_regs();
    rd(`USF_OFS_STATUS, 32'hc0);
    rd(`USF_OFS_IMASK, 32'h3f);
    rd(8'h40, 32'h0);
    wb(1'b1, `USF_OFS_STATUS, 32'h0);
    rd(`USF_OFS_STATUS, 32'hc0);
  endtask : s_regs
  task automatic s_tx();
    wb(1'b1, `USF_OFS_CTRL2, 32'hc0);
    rd(`USF_OFS_STATUS, 32'hc0);
    wb(1'b1, `USF_OFS_DATA, 32'h5a);
    late("full", full, 1);
    peer.txEv(1, 0, usf_pkg::USF_FRAME_DATA);
    late("irq", irq, 1);
    wb(1'b1, `USF_OFS_DATA, 32'h33);
    late("full", full, 0);
    check("hold", hold, 32'h33);
    peer.txEv(0, 1, usf_pkg::USF_FRAME_PREAMBLE);
    peer.txEv(0, 1, usf_pkg::USF_FRAME_BREAK);
    rd(`USF_OFS_STATUS, 32'h80);
    peer.txEv(0, 1, usf_pkg::USF_FRAME_DATA);
    rd(`USF_OFS_STATUS, 32'hc0);
    wb(1'b1, `USF_OFS_IMASK, 32'h0);
    late("irq", irq, 0);
    wb(1'b1, `USF_OFS_IMASK, 32'h3f);
    late("irq", irq, 1);
    wb(1'b1, `USF_OFS_ISTAT, 32'h3f);
    late("irq", irq, 0);
  endtask : s_tx
  task automatic s_rx();
    peer.rxSend(9'h1a5, 1, 0, 0);
    rd(`USF_OFS_STATUS, 32'he4);
    rd(`USF_OFS_DATA, 32'h1a5);
    peer.txEv(0, 0, usf_pkg::USF_FRAME_DATA);
    rd(`USF_OFS_STATUS, 32'hd0);
    wb(1'b0, `USF_OFS_DATA, 32'h0);
    peer.txEv(0, 0, usf_pkg::USF_FRAME_DATA);
    rd(`USF_OFS_STATUS, 32'hc0);
    peer.rxSend(9'h0f0, 0, 0, 1);
    peer.rxSend(9'h10f, 1, 1, 0);
    rd(`USF_OFS_STATUS, 32'he9);
    rd(`USF_OFS_DATA, 32'h0f0);
    rd(`USF_OFS_STATUS, 32'hc0);
  endtask : s_rx
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Reset for sixteen cycles, then the scenarios in turn.
  initial begin
    {rstN, cyc, stb, we, adr, dati} = '0;
    n_fail = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    rstN <= 1'b1;
    s_regs();
    s_tx();
    s_rx();
    report_and_stop();
  end
endmodule : usf_status_flags_tb_top
`default_nettype wire
